/* core/subsystem_regs_pkg.sv */
// Summary of operation
// - Status read shows eight pending flags, vertical sync through video port, in bits 0-7.
// - Writing the status offset is a control word; ones in bits 0-6 clear flags.
// - Control bits 7-13 set the seven interrupt enables: bit 7 for flag 4, bits 8-11 for flags 0-3, bits 12-13 for flags 5-6.
// - Control bits 15-14 select the drawing engine software reset action.
// - Feature control bit 0 is read/write and enables the accelerated display modes.
// - Feature bit 4 enables linear addressing; bits 9-6 read bus interface FIFO status.
// - Video DMA address holds start address in 31-2; bit 1 selects DMA write.
// - Video DMA length holds word count in 23-2; bits 1-0 and 31-24 reserved.
// - Video DMA runs only while enable bit 0 is set; software sets it last.
// - Command ring base in bits 31-12; bit 1 picks a 4 KByte or 64 KByte ring.
// - Software writes pointer 15-2 and flag bit 16; device shows read pointer 15-2.
package subsystem_regs_pkg;

  localparam logic [15:0] OFS_STATUS      = 16'h8504;
  localparam logic [15:0] OFS_FEATURE     = 16'h850c;
  localparam logic [15:0] OFS_VDMA_ADDR   = 16'h8580;
  localparam logic [15:0] OFS_VDMA_LEN    = 16'h8584;
  localparam logic [15:0] OFS_VDMA_EN     = 16'h8588;
  localparam logic [15:0] OFS_RING_BASE   = 16'h8590;
  localparam logic [15:0] OFS_RING_WPTR   = 16'h8594;
  localparam logic [15:0] OFS_RING_RPTR   = 16'h8598;
  localparam logic [15:0] OFS_RING_EN     = 16'h859c;

  // Pending flag positions in the status word.
  localparam int EV_VSYNC      = 0;
  localparam int EV_ENGINE     = 1;
  localparam int EV_FIFO_OVF   = 2;
  localparam int EV_FIFO_EMPTY = 3;
  localparam int EV_HOST_DMA   = 4;
  localparam int EV_CMD_DMA    = 5;
  localparam int EV_ENG_FIFO   = 6;
  localparam int EV_VIDEO_PORT = 7;
  localparam int NUM_EVENTS    = 8;
  localparam int NUM_CLEARABLE = 7;

  // Control and status word fields.
  localparam int CTL_EN_LSB    = 7;
  localparam int CTL_RST_LSB   = 14;
  localparam int ST_SLOTS_LSB  = 8;
  localparam int ST_IDLE_BIT   = 13;

  // Feature control fields.
  localparam int FEAT_ACCEL    = 0;
  localparam int FEAT_LINEAR   = 4;
  localparam int FEAT_BIU_LSB  = 6;

  localparam int VDMA_WRITE    = 1;
  localparam int RING_SIZE_BIT = 1;
  localparam int WPTR_UPD_BIT  = 16;
  localparam int PTR_W         = 14;
  localparam int PTR_LSB       = 2;
  localparam int VDMA_ADDR_LSB = 2;
  localparam int VDMA_ADDR_W   = 30;
  localparam int VDMA_LEN_LSB  = 2;
  localparam int VDMA_LEN_W    = 22;
  localparam int RING_BASE_LSB = 12;
  localparam int RING_BASE_W   = 20;

  localparam logic [PTR_W-1:0] PTR_MASK_4K  = 14'h03ff;
  localparam logic [PTR_W-1:0] PTR_MASK_64K = 14'h3fff;
  localparam logic [31:0]      ZERO_WORD    = 32'h0000_0000;

  typedef struct packed {
    logic [29:0] address;
    logic        write;
    logic [21:0] length;
    logic        run;
  } video_dma_type;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } fetch_type;

endpackage : subsystem_regs_pkg

/* core/subsystem_regs.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module subsystem_regs (
  // Clock and reset.
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // Register port.
  input  wire logic [15:0]                   i_addr,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [31:0]                   o_rdata,
  // Event sources and engine state.
  input  wire logic [subsystem_regs_pkg::NUM_EVENTS-1:0] i_event,
  input  wire logic                          i_video_port_irq,
  input  wire logic [4:0]                    i_engine_slots_free,
  input  wire logic                          i_engine_idle,
  input  wire logic [3:0]                    i_biu_fifo_status,
  // Interrupt.
  output logic                               o_irq,
  // Control outputs.
  output logic [1:0]                         o_engine_reset_select,
  output logic                               o_accel_modes,
  output logic                               o_linear_addressing,
  output subsystem_regs_pkg::video_dma_type  o_video_dma,
  // Command ring fetch.
  output subsystem_regs_pkg::fetch_type      o_fetch,
  input  wire logic                          i_fetch_ack,
  input  wire logic [31:0]                   i_fetch_data,
  output logic [31:0]                        o_cmd_word,
  output logic                               o_cmd_valid
);
  import subsystem_regs_pkg::*;

  logic [NUM_EVENTS-1:0]    status_q;
  logic [NUM_EVENTS-1:0]    status_d;
  logic [NUM_CLEARABLE-1:0] enable_q;
  logic [1:0]               reset_sel_q;
  logic                     accel_q;
  logic                     linear_q;
  logic [29:0]              vdma_addr_q;
  logic                     vdma_write_q;
  logic [21:0]              vdma_len_q;
  logic                     vdma_run_q;
  logic [19:0]              ring_base_q;
  logic                     ring_64k_q;
  logic [PTR_W-1:0]         wptr_q;
  logic                     wptr_upd_q;
  logic [PTR_W-1:0]         rptr_q;
  logic                     ring_en_q;
  logic                     fetch_req_q;
  logic [31:0]              rdata_q;
  logic [31:0]              cmd_word_q;
  logic                     cmd_valid_q;
  logic                     cmd_done_q;

  // Address decode.
  wire sel_status = (i_addr == OFS_STATUS);
  wire sel_feat   = (i_addr == OFS_FEATURE);
  wire sel_vaddr  = (i_addr == OFS_VDMA_ADDR);
  wire sel_vlen   = (i_addr == OFS_VDMA_LEN);
  wire sel_ven    = (i_addr == OFS_VDMA_EN);
  wire sel_base   = (i_addr == OFS_RING_BASE);
  wire sel_wptr   = (i_addr == OFS_RING_WPTR);
  wire sel_rptr   = (i_addr == OFS_RING_RPTR);
  wire sel_ren    = (i_addr == OFS_RING_EN);

  wire wr_ctl = i_wr & sel_status;

  // Ring pointer arithmetic; the wrap follows the selected ring size.
  wire [PTR_W-1:0] ptr_mask  = ring_64k_q ? PTR_MASK_64K : PTR_MASK_4K;
  wire [PTR_W-1:0] rptr_inc  = rptr_q + 14'h0001;
  wire [PTR_W-1:0] rptr_next = (rptr_q & ~ptr_mask) | (rptr_inc & ptr_mask);
  wire             ptrs_meet = ((rptr_q ^ wptr_q) & ptr_mask) == 14'h0000;
  wire             next_meet = ((rptr_next ^ wptr_q) & ptr_mask) == 14'h0000;
  wire             fetch_go  = ring_en_q & ~ptrs_meet & ~fetch_req_q;
  wire             fetch_fin = fetch_req_q & i_fetch_ack;

  // In a 64 KByte ring the pointer covers address bits 15-12 as well.
  wire [3:0]  addr_mid   = ring_64k_q ? rptr_q[13:10] : ring_base_q[3:0];
  wire [31:0] fetch_addr = {ring_base_q[19:4], addr_mid, rptr_q[9:0], 2'b00};

  // Sticky flags: a new event wins over a clear in the same cycle.
  wire [NUM_CLEARABLE-1:0] clr_bits = wr_ctl ? i_wdata[NUM_CLEARABLE-1:0] : 7'h00;
  wire [NUM_EVENTS-1:0]    ev_in;

  genvar g;
  generate
    for (g = 0; g < NUM_EVENTS; g++)
    begin : g_event
      if (g == EV_CMD_DMA)
      begin : g_cmd
        assign ev_in[g] = i_event[g] | cmd_done_q;
      end
      else
      begin : g_ext
        assign ev_in[g] = i_event[g];
      end
      if (g < NUM_CLEARABLE)
      begin : g_sticky
        assign status_d[g] = ev_in[g] | (status_q[g] & ~clr_bits[g]);
      end
      else
      begin : g_level
        // The video port keeps its own flags, so this bit follows its line.
        assign status_d[g] = i_video_port_irq | ev_in[g];
      end
    end
  endgenerate

  // Enables are written in a different order from the flags.
  wire [NUM_EVENTS-1:0] enable_by_flag = {
    1'b1,
    enable_q[6],
    enable_q[5],
    enable_q[0],
    enable_q[4],
    enable_q[3],
    enable_q[2],
    enable_q[1]
  };

  assign o_irq = |(status_q & enable_by_flag);

  // Read multiplexer.
  wire [31:0] rd_status = {18'h0_0000, i_engine_idle, i_engine_slots_free, status_q};
  wire [31:0] rd_feat   = {22'h00_0000, i_biu_fifo_status, 1'b0, linear_q, 3'b000,
                           accel_q};
  wire [31:0] rd_vaddr  = {vdma_addr_q, vdma_write_q, 1'b0};
  wire [31:0] rd_vlen   = {8'h00, vdma_len_q, 2'b00};
  wire [31:0] rd_ven    = {31'h0000_0000, vdma_run_q};
  wire [31:0] rd_base   = {ring_base_q, 10'h000, ring_64k_q, 1'b0};
  wire [31:0] rd_wptr   = {15'h0000, wptr_upd_q, wptr_q, 2'b00};
  wire [31:0] rd_rptr   = {16'h0000, rptr_q, 2'b00};
  wire [31:0] rd_ren    = {31'h0000_0000, ring_en_q};

  wire [31:0] rd_mux =
      sel_status ? rd_status :
      sel_feat   ? rd_feat   :
      sel_vaddr  ? rd_vaddr  :
      sel_vlen   ? rd_vlen   :
      sel_ven    ? rd_ven    :
      sel_base   ? rd_base   :
      sel_wptr   ? rd_wptr   :
      sel_rptr   ? rd_rptr   :
      sel_ren    ? rd_ren    : ZERO_WORD;

  // Software may move the read pointer, but not while a fetch is in flight.
  wire rptr_sw_wr = i_wr & sel_rptr & ~fetch_req_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      status_q <= '0;
      rdata_q  <= ZERO_WORD;
    end
    else
    begin
      status_q <= status_d;
      rdata_q  <= i_rd ? rd_mux : ZERO_WORD;
    end
  end

  // Control word is write-only; enables and reset select only change here.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      enable_q    <= '0;
      reset_sel_q <= 2'b00;
    end
    else if (wr_ctl)
    begin
      enable_q    <= i_wdata[CTL_EN_LSB +: NUM_CLEARABLE];
      reset_sel_q <= i_wdata[CTL_RST_LSB +: 2];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      accel_q  <= 1'b0;
      linear_q <= 1'b0;
    end
    else if (i_wr && sel_feat)
    begin
      accel_q  <= i_wdata[FEAT_ACCEL];
      linear_q <= i_wdata[FEAT_LINEAR];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      vdma_addr_q  <= '0;
      vdma_write_q <= 1'b0;
      vdma_len_q   <= '0;
      vdma_run_q   <= 1'b0;
    end
    else
    begin
      if (i_wr && sel_vaddr)
      begin
        vdma_addr_q  <= i_wdata[VDMA_ADDR_LSB +: VDMA_ADDR_W];
        vdma_write_q <= i_wdata[VDMA_WRITE];
      end
      if (i_wr && sel_vlen)
      begin
        vdma_len_q <= i_wdata[VDMA_LEN_LSB +: VDMA_LEN_W];
      end
      if (i_wr && sel_ven)
      begin
        vdma_run_q <= i_wdata[0];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      ring_base_q <= '0;
      ring_64k_q  <= 1'b0;
      ring_en_q   <= 1'b0;
    end
    else
    begin
      if (i_wr && sel_base)
      begin
        ring_base_q <= i_wdata[RING_BASE_LSB +: RING_BASE_W];
        ring_64k_q  <= i_wdata[RING_SIZE_BIT];
      end
      if (i_wr && sel_ren)
      begin
        ring_en_q <= i_wdata[0];
      end
    end
  end

  // The updated flag drops once the ring drains, unless software sets it again.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wptr_q     <= '0;
      wptr_upd_q <= 1'b0;
    end
    else if (i_wr && sel_wptr)
    begin
      wptr_q     <= i_wdata[PTR_LSB +: PTR_W];
      wptr_upd_q <= i_wdata[WPTR_UPD_BIT];
    end
    else if (fetch_fin && next_meet)
    begin
      wptr_upd_q <= 1'b0;
    end
  end

  // Fetch engine: one outstanding word request at a time.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      rptr_q      <= '0;
      fetch_req_q <= 1'b0;
      cmd_word_q  <= ZERO_WORD;
      cmd_valid_q <= 1'b0;
      cmd_done_q  <= 1'b0;
    end
    else
    begin
      cmd_valid_q <= fetch_fin;
      cmd_done_q  <= fetch_fin & next_meet;
      if (fetch_fin)
      begin
        fetch_req_q <= 1'b0;
        rptr_q      <= rptr_next;
        cmd_word_q  <= i_fetch_data;
      end
      else if (rptr_sw_wr)
      begin
        rptr_q <= i_wdata[PTR_LSB +: PTR_W];
      end
      else if (fetch_go)
      begin
        fetch_req_q <= 1'b1;
      end
    end
  end

  assign o_rdata               = rdata_q;
  assign o_engine_reset_select = reset_sel_q;
  assign o_accel_modes         = accel_q;
  assign o_linear_addressing   = linear_q;
  assign o_video_dma.address   = vdma_addr_q;
  assign o_video_dma.write     = vdma_write_q;
  assign o_video_dma.length    = vdma_len_q;
  assign o_video_dma.run       = vdma_run_q;
  assign o_fetch.req           = fetch_req_q;
  assign o_fetch.addr          = fetch_addr;
  assign o_cmd_word            = cmd_word_q;
  assign o_cmd_valid           = cmd_valid_q;

endmodule : subsystem_regs

/* testbench/subsystem_regs_properties.sv */
`timescale 1ns/1ps
module subsystem_regs_checker (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_video_port_irq,
  input wire logic [3:0]  i_biu_fifo_status,
  input wire logic        o_irq,
  input wire logic [1:0]  o_engine_reset_select,
  input wire logic        o_accel_modes,
  input wire logic        o_linear_addressing,
  input wire subsystem_regs_pkg::video_dma_type o_video_dma,
  input wire subsystem_regs_pkg::fetch_type     o_fetch,
  input wire logic        i_fetch_ack,
  input wire logic [31:0] i_fetch_data,
  input wire logic [31:0] o_cmd_word,
  input wire logic        o_cmd_valid
);
  import subsystem_regs_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire w_st = i_wr && i_addr == OFS_STATUS;
  wire w_ft = i_wr && i_addr == OFS_FEATURE;
  wire w_va = i_wr && i_addr == OFS_VDMA_ADDR;
  wire w_vl = i_wr && i_addr == OFS_VDMA_LEN;
  wire w_ve = i_wr && i_addr == OFS_VDMA_EN;
  wire take = o_fetch.req && i_fetch_ack;
  property p_idle; !i_rd |=> o_rdata == ZERO_WORD; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_vport; i_video_port_irq [*2] |-> o_irq; endproperty
  a_vport: assert property (p_vport) else $error("video port flag lost");
  property p_biu;
    i_rd && i_addr == OFS_FEATURE |=> o_rdata[9:6] == $past(i_biu_fifo_status);
  endproperty
  a_biu: assert property (p_biu) else $error("fifo status read wrong");
  property p_rsel; w_st |=> o_engine_reset_select == $past(i_wdata[15:14]); endproperty
  a_rsel: assert property (p_rsel) else $error("reset select wrong");
  property p_feat;
    w_ft |=> {o_accel_modes, o_linear_addressing} == {$past(i_wdata[0]), $past(i_wdata[4])};
  endproperty
  a_feat: assert property (p_feat) else $error("feature bits wrong");
  property p_vaddr;
    w_va |=> {o_video_dma.address, o_video_dma.write} == $past(i_wdata[31:1]);
  endproperty
  a_vaddr: assert property (p_vaddr) else $error("video address wrong");
  property p_vlen; w_vl |=> o_video_dma.length == $past(i_wdata[23:2]); endproperty
  a_vlen: assert property (p_vlen) else $error("video length wrong");
  property p_run; w_ve |=> o_video_dma.run == $past(i_wdata[0]); endproperty
  a_run: assert property (p_run) else $error("video enable wrong");
  property p_hold;
    o_fetch.req && !i_fetch_ack |=> o_fetch.req && $stable(o_fetch.addr);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch dropped early");
  property p_word; take |=> o_cmd_valid && o_cmd_word == $past(i_fetch_data); endproperty
  a_word: assert property (p_word) else $error("command word wrong");
  property p_cause; o_cmd_valid |-> $past(take); endproperty
  a_cause: assert property (p_cause) else $error("stray command valid");
endmodule : subsystem_regs_checker
bind subsystem_regs subsystem_regs_checker u_checker (.*);

/* testbench/fetch_memory.sv */
`timescale 1ns/1ps
module fetch_memory (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  input  wire subsystem_regs_pkg::fetch_type i_fetch,
  input  wire logic [3:0]                   i_delay,
  output logic                              o_ack,
  output logic [31:0]                       o_data
);
  import subsystem_regs_pkg::*;
  logic [3:0] wait_q;
  // Data toggles while idle so a stale word can never pass as fresh.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wait_q <= 4'h0;
      o_ack  <= 1'b0;
      o_data <= 32'h5a5a_5a5a;
    end
    else if (i_fetch.req && !o_ack && wait_q == i_delay)
    begin
      o_ack  <= 1'b1;
      o_data <= ~i_fetch.addr;
      wait_q <= 4'h0;
    end
    else
    begin
      o_ack  <= 1'b0;
      o_data <= ~o_data;
      wait_q <= (i_fetch.req && !o_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : fetch_memory

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import subsystem_regs_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_video_port_irq = 0;
  logic i_engine_idle = 1, o_irq, o_accel_modes, o_linear_addressing, i_fetch_ack, o_cmd_valid;
  logic [15:0] i_addr = 16'h0000;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, o_cmd_word, i_fetch_data, q;
  logic [7:0] i_event = 8'h00;
  logic [4:0] i_engine_slots_free = 5'h15;
  logic [3:0] i_biu_fifo_status = 4'ha, delay = 4'h0;
  logic [1:0] o_engine_reset_select;
  video_dma_type o_video_dma;
  fetch_type o_fetch;
  logic [31:0] addr_q[$], word_q[$];
  int failures = 0, n_tests = 0, cycles = 0;
  subsystem_regs dut (.*);
  fetch_memory mem (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fetch(o_fetch),
    .i_delay(delay), .o_ack(i_fetch_ack), .o_data(i_fetch_data));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    if (o_fetch.req && i_fetch_ack) addr_q.push_back(o_fetch.addr);
    if (o_cmd_valid) word_q.push_back(o_cmd_word);
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
  endtask : rd
  task automatic t_regs;
    wr(OFS_FEATURE, 32'hffff_ffff);
    rd(OFS_FEATURE);
    chk(q, 32'h0000_0291);
    chk({o_accel_modes, o_linear_addressing}, 32'h0000_0003);
    wr(OFS_FEATURE, 32'h0000_0000);
    rd(OFS_FEATURE);
    chk(q, 32'h0000_0280);
    wr(OFS_VDMA_ADDR, 32'hdead_beef);
    rd(OFS_VDMA_ADDR);
    chk(q, 32'hdead_beee);
    chk({o_video_dma.address, o_video_dma.write}, 32'h6f56_df77);
    wr(OFS_VDMA_LEN, 32'hffff_ffff);
    rd(OFS_VDMA_LEN);
    chk(q, 32'h00ff_fffc);
    chk(o_video_dma.run, 1'b0);
    wr(OFS_VDMA_EN, 32'h0000_0001);
    chk(o_video_dma.run, 1'b1);
    rd(16'h8500);
    chk(q, 32'h0000_0000);
  endtask : t_regs
  task automatic t_irq;
    int en[7] = '{8, 9, 10, 11, 7, 12, 13};
    for (int i = 0; i < 7; i++)
    begin
      i_event <= 8'(1 << i);
      @(posedge i_clk);
      i_event <= 8'h00;
      wr(OFS_STATUS, 32'h0000_3f80 ^ (32'h1 << en[i]));
      chk(o_irq, 1'b0);
      rd(OFS_STATUS);
      chk(q, 32'h0000_3500 | (32'h1 << i));
      wr(OFS_STATUS, 32'h1 << en[i]);
      chk(o_irq, 1'b1);
      // The enable stays on, so only a cleared flag can drop the interrupt.
      wr(OFS_STATUS, (32'h1 << i) | (32'h1 << en[i]));
      chk(o_irq, 1'b0);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_STATUS, 32'(k) << 14);
      chk(o_engine_reset_select, 32'(k));
    end
    i_event <= 8'h01;
    wr(OFS_STATUS, 32'h0000_0101);
    i_event <= 8'h00;
    chk(o_irq, 1'b1);
    wr(OFS_STATUS, 32'h0000_0101);
    chk(o_irq, 1'b0);
    i_video_port_irq <= 1'b1;
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    chk(q, 32'h0000_3580);
    chk(o_irq, 1'b1);
    i_video_port_irq <= 1'b0;
  endtask : t_irq
  // Each ring run must start disabled, as a read pointer write is ignored during a fetch.
  task automatic t_ring(input logic [31:0] b, input logic [31:0] rp, input logic [31:0] wp,
                        input logic [3:0] dl, input int n);
    logic [13:0] p;
    delay <= dl;
    wr(OFS_RING_EN, 32'h0000_0000);
    wr(OFS_RING_BASE, b);
    wr(OFS_RING_RPTR, rp);
    wr(OFS_RING_WPTR, wp | 32'h0001_0000);
    addr_q.delete();
    word_q.delete();
    wr(OFS_RING_EN, 32'h0000_0001);
    for (int k = 0; k < 60 && word_q.size() < n; k++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    #1;
    rd(OFS_RING_RPTR);
    chk(q, wp);
    rd(OFS_RING_WPTR);
    chk(q, wp);
    rd(OFS_STATUS);
    chk(q[5], 1'b1);
    chk(word_q.size(), n);
    for (int k = 0; k < n; k++)
    begin
      p = rp[15:2] + 14'(k);
      chk(addr_q[k], {b[31:16], b[1] ? p[13:10] : b[15:12], p[9:0], 2'b00});
      chk(word_q[k], ~addr_q[k]);
    end
    wr(OFS_STATUS, 32'h0000_0020);
  endtask : t_ring
  task automatic wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    #1;
    t_regs();
    t_irq();
    t_ring(32'h1234_5000, 32'h0000_0ff8, 32'h0000_0004, 4'h0, 3);
    t_ring(32'h1234_0002, 32'h0000_1004, 32'h0000_100c, 4'h3, 2);
    wrap_up();
  end
endmodule : tb_top
